// >>> rtl/hemf_beacon_avg.sv
// Exponential average of beacon receive power, weight one sixteenth.
// Assumes samples are signed dBm; the invalid code is ignored.
`timescale 1ns/1ns
`default_nettype none
`include "hemf_regs.svh"
module hemf_beacon_avg (
	// Clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Samples in
	input wire logic sample_valid,
	input wire logic [7:0] sample,
	// Average out
	output logic [7:0] avg
);
	logic signed [11:0] acc_q;
	logic valid_q;
	logic signed [12:0] s_ext;
	logic signed [12:0] a_ext;
	logic signed [12:0] step;
	logic signed [12:0] acc_next;

	// Four fraction bits keep small steps from vanishing
	always_comb
	begin
		s_ext = {sample[7], sample, 4'h0};
		a_ext = {acc_q[11], acc_q};
		step = (s_ext - a_ext) >>> `HEMF_BEACON_SHIFT;
		acc_next = a_ext + step;
	end

	// First valid sample seeds the filter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc_q <= '0;
			valid_q <= 1'b0;
		end
		else if (ce && sample_valid && sample != `HEMF_RSSI_INVALID)
		begin
			valid_q <= 1'b1;
			acc_q <= valid_q ? acc_next[11:0] : s_ext[11:0];
		end
	end

	assign avg = valid_q ? acc_q[11:4] : `HEMF_RSSI_INVALID;
endmodule : hemf_beacon_avg
`default_nettype wire

// >>> rtl/hemf_framer.sv
// Host event message framer: AXI4-Lite register slave and byte framer.
// Assumes one clock, a byte sink with valid/ready, synchronous inputs.
//
// Summary of operation
// [R1] Every message starts with marker byte FB
// [R2] Received-data type 26, length 05 to 6C
// [R3] Received-data sender address bytes three-five, LSB first
// [R4] Received-data signal strength at byte six
// [R5] Payload up to 103 bytes from seven
// [R6] Announcements: type 27, length 02, status three
// [R7] Startup finished sends announcement status A0
// [R8] Bad argument E1, read-only write E4
// [R9] Brownout reset EC, watchdog reset ED
// [R10] Crystal or radio fault reports EE
// [R11] Heartbeat: type 27, length 07, status A8
// [R12] Heartbeat address bytes four-six, LSB first
// [R13] Heartbeat signal strength at byte seven
// [R14] Heartbeat byte eight: averaged beacon power
// [R15] I/O report: type 28, length 12
// [R16] I/O report address, strength, six input levels
// [R17] Three 12-bit converter readings, LSB first
// [R18] Flag bits 0-3: triggering input pins
// [R19] Flag bit 4: periodic interval expired
// [R20] Flag bits 5-7: converter thresholds zero-two
// [R21] Flag bits 8-15 always zero
// [R22] Two output converter settings end report
// [R23] Bytes ascending, whole messages, never interleaved
`timescale 1ns/1ns
`default_nettype none
`include "hemf_regs.svh"
module hemf_framer
	import hemf_pkg::*;
#(
	parameter int AW = 8
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic [AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [AW-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Byte stream to host
	output logic [7:0] tx_data,
	output logic tx_valid,
	output logic tx_last,
	input wire logic tx_ready
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] word_addr(input logic [AW-1:0] a);
		return {a[7:2], 2'b00};
	endfunction : word_addr

	function automatic logic is_mapped(input logic [AW-1:0] a);
		return word_addr(a) <= `HEMF_A_STATUS;
	endfunction : is_mapped

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : merge

	function automatic logic [7:0] hi12(input logic [11:0] v);
		return {4'h0, v[11:8]};
	endfunction : hi12

	// Announcement cause selector to status byte
	function automatic logic [7:0] cause_code(input logic [2:0] c);
		case (c)
			3'h0: return `HEMF_ST_STARTUP; // [R7]
			3'h1: return `HEMF_ST_BAD_ARG; // [R8]
			3'h2: return `HEMF_ST_READ_ONLY; // [R8]
			3'h3: return `HEMF_ST_BROWNOUT; // [R9]
			3'h4: return `HEMF_ST_WATCHDOG; // [R9]
			3'h5: return `HEMF_ST_HW_FAULT; // [R10]
			default: return `HEMF_ST_BAD_ARG;
		endcase
	endfunction : cause_code

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
	logic [1:0] bresp_q;
	logic [AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic arready_q, rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q, rd_word;
	logic [23:0] node_q;
	logic [7:0] rssi_q;
	logic [15:0] io_q;
	logic [11:0] adc0_q, adc1_q, adc2_q, dac0_q, dac1_q;
	logic req_q, boot_q;
	hemf_kind_t req_kind_q, kind_q, nkind;
	logic [2:0] req_cause_q;
	hemf_state_t state_q;
	logic [6:0] idx_q, last_q, nidx;
	logic [7:0] code_q, ncode, nbyte, avg;
	logic [7:0] tx_data_q, pl_data;
	logic tx_valid_q, tx_last_q;
	logic [6:0] pl_count;
	logic wr_fire, start, msg_end;
	logic [7:0] wa;
	logic [31:0] wm;

	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wa = word_addr(awaddr_q);
	assign start = (state_q == st_idle) && (boot_q || req_q);
	assign msg_end = (state_q == st_send) && tx_ready && (idx_q == last_q);

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	// Address and data taken in either order, answered once both are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `HEMF_RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else if (ce)
		begin
			if (awvalid && awready_q)
			begin
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready_q)
			begin
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_fire)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= is_mapped(awaddr_q) ? `HEMF_RESP_OKAY : `HEMF_RESP_SLVERR;
			end
			if (bvalid_q && bready)
			begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Message field registers, byte lanes honoured
	always_comb
	begin
		case (wa)
			`HEMF_A_NODE: wm = merge({8'h00, node_q}, wdata_q, wstrb_q);
			`HEMF_A_SIG: wm = merge({24'h000000, rssi_q}, wdata_q, wstrb_q);
			`HEMF_A_IO: wm = merge({16'h0000, io_q}, wdata_q, wstrb_q);
			`HEMF_A_ADC01: wm = merge({4'h0, adc1_q, 4'h0, adc0_q}, wdata_q, wstrb_q);
			`HEMF_A_ADC2: wm = merge({20'h00000, adc2_q}, wdata_q, wstrb_q);
			`HEMF_A_DAC: wm = merge({4'h0, dac1_q, 4'h0, dac0_q}, wdata_q, wstrb_q);
			default: wm = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			node_q <= 24'h000000;
			rssi_q <= `HEMF_RSSI_INVALID;
			io_q <= 16'h0000;
			adc0_q <= 12'h000;
			adc1_q <= 12'h000;
			adc2_q <= 12'h000;
			dac0_q <= 12'h000;
			dac1_q <= 12'h000;
		end
		else if (ce && wr_fire)
		begin
			case (wa)
				`HEMF_A_NODE: node_q <= wm[23:0];
				`HEMF_A_SIG: rssi_q <= wm[7:0];
				`HEMF_A_IO: io_q <= {wm[15:8], 2'b00, wm[5:0]};
				`HEMF_A_ADC01:
				begin
					adc0_q <= wm[11:0];
					adc1_q <= wm[27:16];
				end
				`HEMF_A_ADC2: adc2_q <= wm[11:0];
				`HEMF_A_DAC:
				begin
					dac0_q <= wm[11:0];
					dac1_q <= wm[27:16];
				end
				default: ;
			endcase
		end
	end

	// One-deep send request; a second request while one waits is dropped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			req_q <= 1'b0;
			req_kind_q <= kind_rxd;
			req_cause_q <= 3'h0;
		end
		else if (ce)
		begin
			// A request landing as the waiting one is taken wins over the clear
			if (wr_fire && wa == `HEMF_A_SEND && wstrb_q[0] &&
				(!req_q || (start && !boot_q)))
			begin
				req_q <= 1'b1;
				req_kind_q <= hemf_kind_t'(wdata_q[1:0]);
				req_cause_q <= wdata_q[`HEMF_CAUSE_LSB +: 3];
			end
			else if (start && !boot_q)
				req_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	always_comb
	begin
		case (word_addr(araddr))
			`HEMF_A_SEND: rd_word = {27'h0000000, req_cause_q, req_kind_q};
			`HEMF_A_NODE: rd_word = {8'h00, node_q};
			`HEMF_A_SIG: rd_word = {24'h000000, rssi_q};
			`HEMF_A_BEACON: rd_word = {24'h000000, avg};
			`HEMF_A_IO: rd_word = {16'h0000, io_q};
			`HEMF_A_ADC01: rd_word = {4'h0, adc1_q, 4'h0, adc0_q};
			`HEMF_A_ADC2: rd_word = {20'h00000, adc2_q};
			`HEMF_A_DAC: rd_word = {4'h0, dac1_q, 4'h0, dac0_q};
			`HEMF_A_STATUS: rd_word = {8'h00, avg, 1'b0, pl_count, 6'h00, req_q,
				state_q == st_send};
			default: rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `HEMF_RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid && arready_q)
			begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= is_mapped(araddr) ? `HEMF_RESP_OKAY : `HEMF_RESP_SLVERR;
			end
			else if (rvalid_q && rready)
			begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	// Payload fills only while nothing is queued or sent, so counts stay put
	hemf_payload_buf #(.DEPTH(`HEMF_PAYLOAD_MAX), .IW(7)) u_buf (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.push(wr_fire && wa == `HEMF_A_PAYLOAD && wstrb_q[0] && !req_q &&
			state_q == st_idle),
		.push_data(wdata_q[7:0]),
		.clear(msg_end && kind_q == kind_rxd),
		.rd_idx(nidx - `HEMF_OFS_RXD_DATA),
		.rd_data(pl_data),
		.count(pl_count)
	); // [R5]

	hemf_beacon_avg u_avg (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.sample_valid(wr_fire && wa == `HEMF_A_BEACON && wstrb_q[0]),
		.sample(wdata_q[7:0]),
		.avg(avg)
	); // [R14]

	// ----------------------------------------
	// Byte builder
	// ----------------------------------------
	always_comb
	begin
		nidx = (state_q == st_idle) ? 7'h00 : idx_q + 7'h01;
		nkind = (state_q == st_idle) ? (boot_q ? kind_ann : req_kind_q) : kind_q;
		ncode = (state_q == st_idle) ? cause_code(boot_q ? 3'h0 : req_cause_q) : code_q;
		nbyte = 8'h00;
		if (nidx == 7'h00)
			nbyte = `HEMF_SOP; // [R1]
		else
		begin
			case (nkind)
				kind_rxd:
					case (nidx)
						7'h01: nbyte = 8'(pl_count) + `HEMF_LEN_RXD_BASE; // [R2]
						7'h02: nbyte = `HEMF_TYPE_RXD; // [R2]
						7'h03: nbyte = node_q[7:0]; // [R3]
						7'h04: nbyte = node_q[15:8]; // [R3]
						7'h05: nbyte = node_q[23:16]; // [R3]
						7'h06: nbyte = rssi_q; // [R4]
						default: nbyte = pl_data; // [R5]
					endcase
				kind_ann:
					case (nidx)
						7'h01: nbyte = `HEMF_LEN_ANN; // [R6]
						7'h02: nbyte = `HEMF_TYPE_ANN; // [R6]
						default: nbyte = ncode; // [R6]
					endcase
				kind_hb:
					case (nidx)
						7'h01: nbyte = `HEMF_LEN_HB; // [R11]
						7'h02: nbyte = `HEMF_TYPE_ANN; // [R11]
						7'h03: nbyte = `HEMF_ST_HEARTBEAT; // [R11]
						7'h04: nbyte = node_q[7:0]; // [R12]
						7'h05: nbyte = node_q[15:8]; // [R12]
						7'h06: nbyte = node_q[23:16]; // [R12]
						7'h07: nbyte = rssi_q; // [R13]
						default: nbyte = avg; // [R14]
					endcase
				default:
					case (nidx)
						7'h01: nbyte = `HEMF_LEN_IO; // [R15]
						7'h02: nbyte = `HEMF_TYPE_IO; // [R15]
						7'h03: nbyte = node_q[7:0]; // [R16]
						7'h04: nbyte = node_q[15:8]; // [R16]
						7'h05: nbyte = node_q[23:16]; // [R16]
						7'h06: nbyte = rssi_q; // [R16]
						7'h07: nbyte = {2'b00, io_q[5:0]}; // [R16]
						7'h08: nbyte = adc0_q[7:0]; // [R17]
						7'h09: nbyte = hi12(adc0_q); // [R17]
						7'h0A: nbyte = adc1_q[7:0]; // [R17]
						7'h0B: nbyte = hi12(adc1_q); // [R17]
						7'h0C: nbyte = adc2_q[7:0]; // [R17]
						7'h0D: nbyte = hi12(adc2_q); // [R17]
						7'h0E: nbyte = io_q[15:8]; // [R18] [R19] [R20]
						7'h0F: nbyte = 8'h00; // [R21]
						7'h10: nbyte = dac0_q[7:0]; // [R22]
						7'h11: nbyte = hi12(dac0_q); // [R22]
						7'h12: nbyte = dac1_q[7:0]; // [R22]
						default: nbyte = hi12(dac1_q); // [R22]
					endcase
			endcase
		end
	end

	// ----------------------------------------
	// Message sequencer
	// ----------------------------------------
	// Kind and length latch at the first byte, so later send requests cannot tear a message; field registers are read live
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= st_idle;
			boot_q <= 1'b1;
			kind_q <= kind_rxd;
			code_q <= 8'h00;
			idx_q <= 7'h00;
			last_q <= 7'h00;
			tx_data_q <= 8'h00;
			tx_valid_q <= 1'b0;
			tx_last_q <= 1'b0;
		end
		else if (ce)
		begin
			case (state_q)
				st_idle:
					if (start)
					begin
						state_q <= st_send;
						boot_q <= 1'b0; // [R7]
						kind_q <= nkind;
						code_q <= ncode;
						idx_q <= 7'h00;
						case (nkind)
							kind_rxd: last_q <= `HEMF_LAST_RXD_BASE + pl_count;
							kind_ann: last_q <= `HEMF_LAST_ANN;
							kind_hb: last_q <= `HEMF_LAST_HB;
							default: last_q <= `HEMF_LAST_IO;
						endcase
						tx_data_q <= nbyte;
						tx_valid_q <= 1'b1;
						tx_last_q <= 1'b0;
					end
				st_send:
					if (tx_ready)
					begin
						if (idx_q == last_q)
						begin
							state_q <= st_idle;
							tx_valid_q <= 1'b0;
							tx_last_q <= 1'b0;
						end
						else
						begin
							idx_q <= nidx; // [R23]
							tx_data_q <= nbyte;
							tx_last_q <= (nidx == last_q);
						end
					end
				default: state_q <= st_idle;
			endcase
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign tx_data = tx_data_q;
	assign tx_valid = tx_valid_q;
	assign tx_last = tx_last_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_start_marker: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		tx_valid_q && idx_q == 7'h00 |-> tx_data_q == `HEMF_SOP)
		else $error("message does not open with marker");
	a_rxd_type: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		tx_valid_q && kind_q == kind_rxd && idx_q == 7'h02 |-> tx_data_q == `HEMF_TYPE_RXD)
		else $error("received-data type byte wrong");
	a_rxd_len: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		tx_valid_q && kind_q == kind_rxd && idx_q == 7'h01 |->
		tx_data_q == last_q + 7'h01 - 7'h02 && tx_data_q <= `HEMF_LEN_RXD_MAX)
		else $error("received-data length byte wrong");
	a_ann_length: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		tx_valid_q && kind_q == kind_ann && idx_q == 7'h01 |-> tx_data_q == `HEMF_LEN_ANN)
		else $error("announcement length wrong");
	a_ann_ends: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		tx_valid_q && tx_last_q && kind_q == kind_ann |-> idx_q == 7'h03)
		else $error("announcement not four bytes");
	// Sampled reset in the antecedent: the release edge itself still resets the logic
	a_boot_announce: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		aresetn && ce && state_q == st_idle && boot_q |=> tx_valid_q && kind_q == kind_ann &&
		tx_data_q == `HEMF_SOP ##3 tx_data_q == `HEMF_ST_STARTUP || !tx_valid_q || !ce)
		else $error("startup announcement missing");
	a_hb_status: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
		tx_valid_q && kind_q == kind_hb && idx_q == 7'h03 |-> tx_data_q == `HEMF_ST_HEARTBEAT)
		else $error("heartbeat status wrong");
	a_io_length: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
		tx_valid_q && kind_q == kind_io && idx_q == 7'h01 |-> tx_data_q == `HEMF_LEN_IO)
		else $error("report length wrong");
	a_flags_high: assert property (@(posedge aclk) disable iff (!aresetn) // [R21]
		tx_valid_q && kind_q == kind_io && idx_q == 7'h0F |-> tx_data_q == 8'h00)
		else $error("upper flag byte not zero");
	a_byte_order: assert property (@(posedge aclk) disable iff (!aresetn) // [R23]
		ce && tx_valid_q && tx_ready && !tx_last_q |=>
		tx_valid_q && idx_q == $past(idx_q) + 7'h01)
		else $error("bytes out of order");
	a_byte_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R23]
		tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q) && $stable(kind_q))
		else $error("byte changed while stalled");
endmodule : hemf_framer
`default_nettype wire

// >>> rtl/hemf_payload_buf.sv
// Payload store of the received-data event, flip-flops by index.
// Assumes pushes only while no message is being emitted.
`timescale 1ns/1ns
`default_nettype none
`include "hemf_regs.svh"
module hemf_payload_buf #(
	parameter int DEPTH = `HEMF_PAYLOAD_MAX,
	parameter int IW = 7
) (
	// Clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Fill side
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic clear,
	// Read side
	input wire logic [IW-1:0] rd_idx,
	output logic [7:0] rd_data,
	output logic [IW-1:0] count
);
	logic [7:0] mem_q [DEPTH];
	logic [IW-1:0] count_q;

	// Fill pointer; pushes beyond depth are dropped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_q <= '0;
		else if (ce)
		begin
			if (clear)
				count_q <= '0;
			else if (push && count_q < IW'(DEPTH))
				count_q <= count_q + IW'(1);
		end
	end

	// Storage needs no reset, count guards stale bytes
	always_ff @(posedge aclk)
	begin
		if (ce && !clear && push && count_q < IW'(DEPTH))
			mem_q[count_q] <= push_data;
	end

	assign rd_data = (rd_idx < IW'(DEPTH)) ? mem_q[rd_idx] : 8'h00;
	assign count = count_q;
endmodule : hemf_payload_buf
`default_nettype wire

// >>> rtl/hemf_pkg.sv
// Types shared by the host event message framer files.
// Assumes nothing of its surroundings.
`default_nettype none
package hemf_pkg;
	// Message kinds selectable by software
	typedef enum logic [1:0] {kind_rxd, kind_ann, kind_hb, kind_io} hemf_kind_t;
	// Framer sequencing states
	typedef enum logic {st_idle, st_send} hemf_state_t;
endpackage : hemf_pkg
`default_nettype wire

// >>> rtl/hemf_regs.svh
// Constants of the host event message framer: byte codes, offsets,
// register addresses and field positions.
// Assumes inclusion by bare name from the framer, payload buffer and beacon average source files.
`ifndef HEMF_REGS_SVH
`define HEMF_REGS_SVH

// ----------------------------------------
// Message framing bytes
// ----------------------------------------
`define HEMF_SOP 8'hFB
`define HEMF_TYPE_RXD 8'h26
`define HEMF_TYPE_ANN 8'h27
`define HEMF_TYPE_IO 8'h28
`define HEMF_LEN_ANN 8'h02
`define HEMF_LEN_HB 8'h07
`define HEMF_LEN_IO 8'h12
`define HEMF_LEN_RXD_BASE 8'h05
`define HEMF_LEN_RXD_MAX 8'h6C
`define HEMF_RSSI_INVALID 8'h7F
`define HEMF_PAYLOAD_MAX 103

// ----------------------------------------
// Status bytes of announcements
// ----------------------------------------
`define HEMF_ST_STARTUP 8'hA0
`define HEMF_ST_BAD_ARG 8'hE1
`define HEMF_ST_READ_ONLY 8'hE4
`define HEMF_ST_BROWNOUT 8'hEC
`define HEMF_ST_WATCHDOG 8'hED
`define HEMF_ST_HW_FAULT 8'hEE
`define HEMF_ST_HEARTBEAT 8'hA8

// ----------------------------------------
// Last byte offsets and payload start
// ----------------------------------------
`define HEMF_LAST_ANN 7'h03
`define HEMF_LAST_HB 7'h08
`define HEMF_LAST_IO 7'h13
`define HEMF_LAST_RXD_BASE 7'h06
`define HEMF_OFS_RXD_DATA 7'h07

// ----------------------------------------
// Register byte addresses and fields
// ----------------------------------------
`define HEMF_A_SEND 8'h00
`define HEMF_A_NODE 8'h04
`define HEMF_A_SIG 8'h08
`define HEMF_A_BEACON 8'h0C
`define HEMF_A_IO 8'h10
`define HEMF_A_ADC01 8'h14
`define HEMF_A_ADC2 8'h18
`define HEMF_A_DAC 8'h1C
`define HEMF_A_PAYLOAD 8'h20
`define HEMF_A_STATUS 8'h24
`define HEMF_CAUSE_LSB 4
`define HEMF_RESP_OKAY 2'h0
`define HEMF_RESP_SLVERR 2'h2
// Averaging weight 0.0625 is a right shift by four
`define HEMF_BEACON_SHIFT 4

`endif

// >>> tb/hemf_framer_bench.sv
// Self-checking bench of the host event message framer.
// Assumes hemf_framer with AW 8 and the host sink model.
`timescale 1ns/1ns
`default_nettype none
module hemf_framer_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stall;
	logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_last, tx_ready;
	logic [7:0] awaddr, araddr, tx_data, sig, b;
	logic [31:0] wdata, rdata, r;
	logic [1:0] bresp, rresp;
	logic [23:0] node;
	logic [8:0] e;
	logic [8:0] expq[$];
	logic [7:0] pl[$];
	logic [31:0] v[4];
	logic [7:0] st[8] = '{8'hA0, 8'hE1, 8'hE4, 8'hEC, 8'hED, 8'hEE, 8'hE1, 8'hE1};
	int cnt[2] = '{104, 0};
	int err_total, checks, cyc, i, j;

	hemf_framer i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
	hemf_host_sink i_sink (.aclk(aclk), .aresetn(aresetn), .stall(stall),
		.tx_ready(tx_ready));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask : cmp

	task complete_run;
		$display("Checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// Address and data may go at different edges; each is let go when taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge aclk);
			ad = ad || awready === 1'b1;
			dd = dd || wready === 1'b1;
			if (ad)
				awvalid <= 1'b0;
			if (dd)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		bready <= 1'b0;
		cmp("bresp", x, bresp);
	endtask : wr

	task rdr(input logic [7:0] a, input logic [1:0] x, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk);
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		cmp("rresp", x, rresp);
	endtask : rdr

	// Poll status until nothing sends and nothing waits
	task idle;
		do rdr(8'h24, 2'h0, r);
		while (r[1:0] !== 2'h0);
	endtask : idle

	task msg(input logic [7:0] q[$]);
		foreach (q[k])
			expq.push_back({k == q.size() - 1, q[k]});
	endtask : msg

	// ----------------------------------------
	// Clock and output monitor
	// ----------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Each accepted byte takes the oldest note off the queue
	always @(posedge aclk)
	begin
		cyc++;
		if (aresetn && tx_valid && tx_ready)
		begin
			cmp("note waiting", 1, expq.size() > 0);
			e = expq.size() > 0 ? expq.pop_front() : 9'h1FF;
			cmp("tx_data", e[7:0], tx_data);
			cmp("tx_last", e[8], tx_last);
		end
		if (cyc == 20000)
		begin
			err_total++;
			complete_run;
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, stall} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		void'($urandom(14));
		msg('{8'hFB, 8'h02, 8'h27, 8'hA0});
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(8'h08, 2'h0, r);
		cmp("sig reset", 32'h7F, r);
		rdr(8'h0C, 2'h0, r);
		cmp("beacon reset", 32'h7F, r);
		rdr(8'h28, 2'h2, r);
		cmp("unmapped rdata", 32'h0, r);
		wr(8'h40, 32'h1, 2'h2);
		idle;
		$display("Test startup done");
		stall <= 1'b1;
		for (i = 0; i < 8; i++)
		begin
			msg('{8'hFB, 8'h02, 8'h27, st[i]});
			wr(8'h00, {25'h0, i[2:0], 4'h1}, 2'h0);
			idle;
		end
		$display("Test announce done");
		node = 24'($urandom);
		sig = 8'($urandom);
		wr(8'h04, {8'h0, node}, 2'h0);
		wr(8'h08, {24'h0, sig}, 2'h0);
		wr(8'h0C, 32'hC8, 2'h0);
		wr(8'h0C, 32'hD8, 2'h0);
		wr(8'h0C, 32'h7F, 2'h0);
		rdr(8'h0C, 2'h0, r);
		cmp("beacon avg", 32'hC9, r);
		msg('{8'hFB, 8'h07, 8'h27, 8'hA8, node[7:0], node[15:8], node[23:16],
			sig, 8'hC9});
		wr(8'h00, 32'h2, 2'h0);
		idle;
		$display("Test heartbeat done");
		foreach (v[k])
			v[k] = $urandom;
		for (j = 0; j < 2; j++)
		begin
			foreach (v[k])
				wr(8'h10 + 8'(4 * k), v[k], 2'h0);
			msg('{8'hFB, 8'h12, 8'h28, node[7:0], node[15:8], node[23:16], sig,
				{2'h0, v[0][5:0]}, v[1][7:0], {4'h0, v[1][11:8]}, v[1][23:16],
				{4'h0, v[1][27:24]}, v[2][7:0], {4'h0, v[2][11:8]}, v[0][15:8],
				8'h00, v[3][7:0], {4'h0, v[3][11:8]}, v[3][23:16],
				{4'h0, v[3][27:24]}});
			wr(8'h00, 32'h3, 2'h0);
			idle;
			v[0] = v[0] ^ 32'h0000FF00;
		end
		$display("Test io report done");
		foreach (cnt[k])
		begin
			pl = '{8'hFB, 8'(5 + (cnt[k] > 103 ? 103 : cnt[k])), 8'h26, node[7:0],
				node[15:8], node[23:16], sig};
			for (i = 0; i < cnt[k]; i++)
			begin
				b = 8'($urandom);
				wr(8'h20, {24'h0, b}, 2'h0);
				if (i < 103)
					pl.push_back(b);
			end
			rdr(8'h24, 2'h0, r);
			cmp("payload count", cnt[k] > 103 ? 103 : cnt[k], r[14:8]);
			msg(pl);
			wr(8'h00, 32'h0, 2'h0);
			idle;
		end
		$display("Test received data done");
		repeat (4) @(posedge aclk);
		cmp("notes left", 0, expq.size());
		complete_run;
	end
endmodule : hemf_framer_bench
`default_nettype wire

// >>> tb/hemf_host_sink.sv
// Host byte sink model of the framer stream.
// Assumes the bench seeds $urandom before stalls are asked for.
`timescale 1ns/1ns
`default_nettype none
module hemf_host_sink (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Mode and stream
	input wire logic stall,
	output logic tx_ready
);
	// Ready moves only after an edge; stalls prove bytes are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tx_ready <= 1'b0;
		else
			tx_ready <= !stall || ($urandom % 3 != 0);
	end
endmodule : hemf_host_sink
`default_nettype wire
